// ---- usrx_pkg.sv ----
// Package for the receive control and baud generator block
package usrx_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_RX_CTRL = 8'h18;
    localparam logic [7:0] ADDR_RX_DATA = 8'h1a;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h98;
    localparam logic [7:0] ADDR_BAUD_DIV = 8'h99;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h9c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h9d;
    // Reset values
    localparam logic [7:0] RX_CTRL_RST = 8'h00;
    localparam logic [7:0] TX_CTRL_RST = 8'h02;
    localparam logic [7:0] BAUD_DIV_RST = 8'h00;
    // Receive control bit positions
    localparam int RC_SERIAL_PORT_ENABLE = 7;
    localparam int RC_RX9 = 6;
    localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
    localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RC_FRAMING_ERROR_FLAG = 2;
    localparam int RC_OVERRUN_ERROR_FLAG = 1;
    localparam int RC_RX_NINTH_BIT = 0;
    // Transmit control bit positions
    localparam int TC_CLOCK_SOURCE_SELECT = 7;
    localparam int TC_SYNC = 4;
    localparam int TC_HIGH_SPEED_BAUD_SELECT = 2;
    // Writable masks and forced read-only bits
    localparam logic [7:0] RC_WMASK = 8'hf0;
    localparam logic [7:0] TC_WMASK = 8'hf5;
    localparam logic [7:0] TC_RO_BITS = 8'h02;
    // Last prescaler count per mode (baud multiplier minus one)
    localparam logic [5:0] DIV_ASYNC_LOW = 6'h3f;
    localparam logic [5:0] DIV_ASYNC_HIGH = 6'h0f;
    localparam logic [5:0] DIV_SYNC = 6'h03;
    // Oversampling of the asynchronous bit
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] SAMP_A = 4'h7;
    localparam logic [3:0] SAMP_B = 4'h8;
    localparam logic [3:0] SAMP_C = 4'h9;
    // Interrupt status bits
    localparam int IRQ_RXDONE = 0;
    localparam int IRQ_FRAMING_ERROR_FLAG = 1;
    localparam int IRQ_OVERRUN_ERROR_FLAG = 2;
    localparam int IRQ_W = 3;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usrx_bus_t;

    // Received character
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic framing_error_flag;
    } usrx_char_t;

    // Three-sample majority decision
    function automatic logic usrx_major(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : usrx_major
endpackage : usrx_pkg

// ---- usrx_baud_gen.sv ----
// Free running baud timer with mode-dependent tick scale
`timescale 1ns/100ps
module usrx_baud_gen
    import usrx_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Configuration
    input wire logic [7:0] divisor,
    input wire logic divisor_wr,
    input wire logic sync_mode,
    input wire logic high_speed,
    // Ticks
    output logic sample_tick,
    output logic bit_tick
);
    logic [7:0] timer_r, timer_nxt;
    logic [5:0] scale_r, scale_nxt;
    logic [5:0] scale_last;

    // Sample tick is 1/16 of a bit only in async mode
    always_comb begin
        if (sync_mode)
            scale_last = DIV_SYNC; // RULE9 RULE7
        else if (high_speed)
            scale_last = DIV_ASYNC_HIGH; // RULE8
        else
            scale_last = DIV_ASYNC_LOW; // RULE8
        timer_nxt = timer_r - 8'h01;
        scale_nxt = scale_r;
        sample_tick = 1'b0;
        bit_tick = 1'b0;
        if (divisor_wr) begin
            timer_nxt = divisor; // RULE11
            scale_nxt = 6'h00;
        end else if (timer_r == 8'h00) begin
            timer_nxt = divisor; // RULE6
            scale_nxt = (scale_r >= scale_last) ? 6'h00 : scale_r + 6'h01;
            // Two strobes per bit, one for each half of the shift clock
            if (sync_mode)
                bit_tick = scale_r[0]; // RULE9
            else
                sample_tick = (scale_r[1:0] == 2'b11) | (scale_last == DIV_ASYNC_HIGH);
        end
    end

    // Timer registers
    always_ff @(posedge clock) begin
        if (reset) begin
            timer_r <= BAUD_DIV_RST;
            scale_r <= 6'h00;
        end else begin
            timer_r <= timer_nxt;
            scale_r <= scale_nxt;
        end
    end

    property p_reload;
        @(posedge clock) disable iff (reset) divisor_wr |=> (timer_r == $past(divisor));
    endproperty
    a_reload: assert property (p_reload) else $error("timer not reloaded on write"); // RULE11

    property p_sync_no_sample;
        @(posedge clock) disable iff (reset) sync_mode |-> !sample_tick;
    endproperty
    a_sync_no_sample: assert property (p_sync_no_sample) else $error("sample tick in sync mode"); // RULE7
endmodule : usrx_baud_gen

// ---- usrx_rx_ctrl.sv ----
// Receive control, status and baud generation for the serial unit
// Operation
// [RULE1] Port enable with direction bits hands both pins to the serial unit.
// [RULE2] Async reception accepts characters only while continuous receive is set.
// [RULE3] Nine-bit select picks 9 or 8 bit reception; ninth bit stored.
// [RULE4] Framing flag is read-only, refreshed on holding read plus next character.
// [RULE5] Overrun flag is read-only, cleared only by clearing continuous receive.
// [RULE6] One free running 8-bit timer serves async and sync modes.
// [RULE7] High speed select matters only in asynchronous mode.
// [RULE8] Async rate is clock over 64 or 16 times divisor plus one.
// [RULE9] Sync rate is clock over 4 times divisor plus one.
// [RULE10] Generated rate drives the link only as master; slave uses peer clock.
// [RULE11] Writing the divisor resets the baud timer at once.
// [RULE12] Receive pin sampled three times mid-bit; majority decides the level.
// [RULE13] Software may prefer high speed for smaller rate error.
// [RULE14] Single receive takes one sync master character then clears; continuous wins.
// [RULE15] Control bit 3 reads zero and ignores writes.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module usrx_rx_ctrl
    import usrx_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // Pins and direction bits
    input wire logic [1:0] pin_dir_in,
    input wire logic rx_data_pin_in,
    input wire logic tx_clock_pin_in,
    output logic tx_clock_pin_out,
    output logic tx_clock_pin_oe,
    output logic pins_serial,
    // Interrupt
    output logic irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} usrx_state_t;

    usrx_bus_t bus;
    usrx_char_t hold_r, hold_nxt;
    usrx_state_t st_r, st_nxt;
    logic [7:0] rc_r, rc_nxt, tc_r, tc_nxt, div_r, div_nxt, rdata_r, rdata_nxt;
    logic [8:0] shift_r, shift_nxt;
    logic [3:0] nbit_r, nbit_nxt, ovs_r, ovs_nxt;
    logic [2:0] samp_r, samp_nxt;
    logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic full_r, full_nxt, sck_r, sck_nxt, ext_q_r;
    logic rx_s1_r, rx_s2_r, ck_s1_r, ck_s2_r;
    logic sample_tick, bit_tick, enable, sync_mode, master, rx_bit, done, framing_error_flag_now;
    logic ext_rise;

    assign bus = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};
    assign sync_mode = tc_r[TC_SYNC];
    assign master = tc_r[TC_CLOCK_SOURCE_SELECT];
    assign enable = rc_r[RC_SERIAL_PORT_ENABLE];

    // Pin ownership
    assign pins_serial = enable & (&pin_dir_in); // RULE1
    assign tx_clock_pin_out = sck_r;
    assign tx_clock_pin_oe = pins_serial & sync_mode & master & (st_r != ST_IDLE); // RULE10
    assign rdata = rdata_r;
    assign irq = |(ist_r & imask_r);

    usrx_baud_gen u_baud (
        .clock(clock),
        .reset(reset),
        .divisor(div_nxt),
        .divisor_wr(bus.wr && bus.addr == ADDR_BAUD_DIV),
        .sync_mode(sync_mode),
        .high_speed(tc_r[TC_HIGH_SPEED_BAUD_SELECT]), // RULE13
        .sample_tick(sample_tick),
        .bit_tick(bit_tick)
    );

    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            ck_s1_r <= 1'b0;
            ck_s2_r <= 1'b0;
            ext_q_r <= 1'b0;
        end else begin
            rx_s1_r <= rx_data_pin_in;
            rx_s2_r <= rx_s1_r;
            ck_s1_r <= tx_clock_pin_in;
            ck_s2_r <= ck_s1_r;
            ext_q_r <= ck_s2_r;
        end
    end

    // Sync bit strobe: own divider as master, peer edge as slave
    assign ext_rise = ck_s2_r & ~ext_q_r;
    assign rx_bit = usrx_major(samp_r); // RULE12

    // Receive sequencer
    always_comb begin
        st_nxt = st_r;
        shift_nxt = shift_r;
        nbit_nxt = nbit_r;
        ovs_nxt = ovs_r;
        samp_nxt = samp_r;
        sck_nxt = sck_r;
        done = 1'b0;
        framing_error_flag_now = 1'b0;
        if (!enable || !(rc_r[RC_CONTINUOUS_RECEIVE_ENABLE] || (sync_mode && master && rc_r[RC_SINGLE_RECEIVE_ENABLE]))) begin
            st_nxt = ST_IDLE; // RULE2
            sck_nxt = 1'b0;
        end else if (sync_mode) begin
            if (st_r == ST_IDLE) begin
                st_nxt = ST_DATA;
                nbit_nxt = 4'h0;
            end else if (master ? bit_tick : ext_rise) begin // RULE10
                sck_nxt = ~sck_r;
                if (!master || sck_r) begin
                    shift_nxt = {rx_s2_r, shift_r[8:1]};
                    nbit_nxt = nbit_r + 4'h1;
                    if (nbit_r == (rc_r[RC_RX9] ? 4'h8 : 4'h7)) begin // RULE3
                        done = 1'b1;
                        st_nxt = ST_IDLE;
                        if (!rc_r[RC_RX9])
                            shift_nxt = {1'b0, rx_s2_r, shift_r[8:2]};
                    end
                end
            end
        end else if (sample_tick) begin
            ovs_nxt = ovs_r + 4'h1;
            if (ovs_r == SAMP_A || ovs_r == SAMP_B || ovs_r == SAMP_C)
                samp_nxt = {samp_r[1:0], rx_s2_r}; // RULE12
            unique case (st_r)
                ST_IDLE: begin
                    ovs_nxt = 4'h0;
                    if (!rx_s2_r)
                        st_nxt = ST_START;
                end
                ST_START: if (ovs_r == OVS_LAST) begin
                    st_nxt = rx_bit ? ST_IDLE : ST_DATA;
                    nbit_nxt = 4'h0;
                end
                ST_DATA: if (ovs_r == OVS_LAST) begin
                    shift_nxt = {rx_bit, shift_r[8:1]};
                    nbit_nxt = nbit_r + 4'h1;
                    if (nbit_r == (rc_r[RC_RX9] ? 4'h8 : 4'h7)) begin // RULE3
                        st_nxt = ST_STOP;
                        if (!rc_r[RC_RX9])
                            shift_nxt = {1'b0, rx_bit, shift_r[8:2]};
                    end
                end
                ST_STOP: if (ovs_r == OVS_LAST) begin
                    done = 1'b1;
                    framing_error_flag_now = ~rx_bit;
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Holding register, control and status
    always_comb begin
        rc_nxt = rc_r;
        tc_nxt = tc_r;
        hold_nxt = hold_r;
        full_nxt = full_r;
        ist_nxt = ist_r;
        div_nxt = div_r;
        imask_nxt = imask_r;
        rdata_nxt = 8'h00;
        if (bus.rd && bus.addr == ADDR_RX_DATA)
            full_nxt = 1'b0; // RULE4
        if (bus.wr && bus.addr == ADDR_RX_CTRL) begin
            rc_nxt = (wdata & RC_WMASK) | (rc_r & ~RC_WMASK & 8'h07); // RULE15
            if (!wdata[RC_CONTINUOUS_RECEIVE_ENABLE])
                rc_nxt[RC_OVERRUN_ERROR_FLAG] = 1'b0; // RULE5
        end
        if (bus.wr && bus.addr == ADDR_TX_CTRL)
            tc_nxt = (wdata & TC_WMASK) | TC_RO_BITS;
        if (bus.wr && bus.addr == ADDR_IRQ_STAT)
            ist_nxt = ist_r & ~wdata[IRQ_W-1:0];
        // Divisor write reaches the baud timer in the same cycle
        if (bus.wr && bus.addr == ADDR_BAUD_DIV)
            div_nxt = wdata; // RULE11
        if (bus.wr && bus.addr == ADDR_IRQ_MASK)
            imask_nxt = wdata[IRQ_W-1:0];
        if (done) begin
            if (sync_mode && !rc_r[RC_CONTINUOUS_RECEIVE_ENABLE])
                rc_nxt[RC_SINGLE_RECEIVE_ENABLE] = 1'b0; // RULE14
            if (full_nxt) begin
                rc_nxt[RC_OVERRUN_ERROR_FLAG] = 1'b1; // RULE5
                ist_nxt[IRQ_OVERRUN_ERROR_FLAG] = 1'b1;
            end else begin
                hold_nxt = '{data: shift_nxt[7:0], ninth: shift_nxt[8], framing_error_flag: framing_error_flag_now};
                rc_nxt[RC_RX_NINTH_BIT] = shift_nxt[8]; // RULE3
                rc_nxt[RC_FRAMING_ERROR_FLAG] = framing_error_flag_now; // RULE4
                full_nxt = 1'b1;
                ist_nxt[IRQ_RXDONE] = 1'b1;
                ist_nxt[IRQ_FRAMING_ERROR_FLAG] = ist_nxt[IRQ_FRAMING_ERROR_FLAG] | framing_error_flag_now;
            end
        end
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_RX_CTRL: rdata_nxt = rc_r;
                ADDR_RX_DATA: rdata_nxt = hold_r.data;
                ADDR_TX_CTRL: rdata_nxt = tc_r;
                ADDR_BAUD_DIV: rdata_nxt = div_r;
                ADDR_IRQ_STAT: rdata_nxt = {5'h00, ist_r};
                ADDR_IRQ_MASK: rdata_nxt = {5'h00, imask_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= ST_IDLE;
            shift_r <= 9'h000;
            nbit_r <= 4'h0;
            ovs_r <= 4'h0;
            samp_r <= 3'h7;
            sck_r <= 1'b0;
            rc_r <= RX_CTRL_RST;
            tc_r <= TX_CTRL_RST;
            div_r <= BAUD_DIV_RST;
            hold_r <= '0;
            full_r <= 1'b0;
            ist_r <= '0;
            imask_r <= '0;
            rdata_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            shift_r <= shift_nxt;
            nbit_r <= nbit_nxt;
            ovs_r <= ovs_nxt;
            samp_r <= samp_nxt;
            sck_r <= sck_nxt;
            rc_r <= rc_nxt;
            tc_r <= tc_nxt;
            div_r <= div_nxt; // RULE6
            imask_r <= imask_nxt;
            hold_r <= hold_nxt;
            full_r <= full_nxt;
            ist_r <= ist_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    property p_bit3_zero;
        @(posedge clock) disable iff (reset) rc_r[3] == 1'b0;
    endproperty
    a_bit3_zero: assert property (p_bit3_zero) else $error("control bit 3 set"); // RULE15

    property p_overrun_error_flag_hold;
        @(posedge clock) disable iff (reset) $fell(rc_r[RC_OVERRUN_ERROR_FLAG]) |-> !rc_r[RC_CONTINUOUS_RECEIVE_ENABLE];
    endproperty
    a_overrun_error_flag_hold: assert property (p_overrun_error_flag_hold) else $error("overrun cleared with receive on"); // RULE5

    property p_no_rx_disabled;
        @(posedge clock) disable iff (reset) (!sync_mode && !rc_r[RC_CONTINUOUS_RECEIVE_ENABLE]) |-> !done;
    endproperty
    a_no_rx_disabled: assert property (p_no_rx_disabled) else $error("character taken while off"); // RULE2

    property p_pins;
        @(posedge clock) disable iff (reset) !enable |-> !pins_serial && !tx_clock_pin_oe;
    endproperty
    a_pins: assert property (p_pins) else $error("pins taken while disabled"); // RULE1

    property p_single_receive_enable_clear;
        @(posedge clock) disable iff (reset)
            (done && sync_mode && !rc_r[RC_CONTINUOUS_RECEIVE_ENABLE] && !(bus.wr && bus.addr == ADDR_RX_CTRL)) |=> !rc_r[RC_SINGLE_RECEIVE_ENABLE];
    endproperty
    a_single_receive_enable_clear: assert property (p_single_receive_enable_clear) else $error("single receive not cleared"); // RULE14

    property p_ninth;
        @(posedge clock) disable iff (reset) (done && !full_r && !rc_r[RC_RX9]) |=> !rc_r[RC_RX_NINTH_BIT];
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit set in 8-bit mode"); // RULE3

    property p_framing_error_flag_ro;
        @(posedge clock) disable iff (reset) (bus.wr && bus.addr == ADDR_RX_CTRL && !done) |=> $stable(rc_r[RC_FRAMING_ERROR_FLAG]);
    endproperty
    a_framing_error_flag_ro: assert property (p_framing_error_flag_ro) else $error("framing flag written"); // RULE4

    property p_rdata;
        @(posedge clock) disable iff (reset) (bus.rd && bus.addr == ADDR_BAUD_DIV) |=> rdata == $past(div_r);
    endproperty
    a_rdata: assert property (p_rdata) else $error("divisor readback wrong"); // RULE6

    property p_slave_oe;
        @(posedge clock) disable iff (reset) (sync_mode && !master) |-> !tx_clock_pin_oe;
    endproperty
    a_slave_oe: assert property (p_slave_oe) else $error("shift clock driven as slave"); // RULE10

    property p_hold_free;
        @(posedge clock) disable iff (reset) (bus.rd && bus.addr == ADDR_RX_DATA && !done) |=> !full_r;
    endproperty
    a_hold_free: assert property (p_hold_free) else $error("holding slot not freed"); // RULE4

    property p_div_hold;
        @(posedge clock) disable iff (reset) !(bus.wr && bus.addr == ADDR_BAUD_DIV) |=> $stable(div_r);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divisor changed without write"); // RULE11
endmodule : usrx_rx_ctrl

// ---- usrx_peer.sv ----
// Serial peer that drives asynchronous frames onto the receive pin
`timescale 1ns/100ps
module usrx_peer (
    // Clock
    input wire logic clock,
    // Receive pin of the device
    output logic line
);
    // Idle line rests at the mark level
    initial line = 1'b1;

    // Start bit, data LSB first, optional ninth bit, stop bit
    task automatic send(input logic [8:0] d, input logic nine, input logic stop,
                        input int per, input logic glitch);
        logic [10:0] f;
        logic b;
        int n;
        f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        n = nine ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < per; c++) begin
                @(posedge clock);
                b = f[i];
                // Short spike mid-bit that only one vote can see
                if (glitch && i == 1 && c >= per / 2 - 1 && c <= per / 2) b = ~b;
                // A bad stop bit is released once the votes are past
                if (i == n - 1 && c >= 7 * per / 8) b = 1'b1;
                line <= b;
            end
        end
    endtask : send
endmodule : usrx_peer

// ---- test_usart_rx_control_baud_gen.sv ----
// Self-checking bench for the receive control and baud generator block
`timescale 1ns/100ps
module test_usart_rx_control_baud_gen
    import usrx_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] pin_dir_in = 2'h0;
    logic tx_clock_pin_in = 1'b0;
    logic rx_data_pin_in, tx_clock_pin_out, tx_clock_pin_oe, pins_serial, irq;
    logic [7:0] rdata;
    int seed, miscompares, compares;

    // 100 MHz clock
    always #5 clock = ~clock;

    // Design and serial peer
    usrx_rx_ctrl i_dut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .pin_dir_in(pin_dir_in), .rx_data_pin_in(rx_data_pin_in),
        .tx_clock_pin_in(tx_clock_pin_in), .tx_clock_pin_out(tx_clock_pin_out),
        .tx_clock_pin_oe(tx_clock_pin_oe), .pins_serial(pins_serial), .irq(irq));
    usrx_peer i_peer (.clock(clock), .line(rx_data_pin_in));

    // Verdict and end of run
    task automatic end_sim;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Register bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rdc
    task automatic chk_irq(input logic exp);
        @(posedge clock);
        #1;
        chk({7'h0, irq}, {7'h0, exp});
    endtask : chk_irq

    // Clocks per bit for a mode and divisor
    function automatic int bit_clocks(input logic sync, input logic high_speed_baud_select, input logic [7:0] dv);
        if (sync) return 4 * (int'(dv) + 1);
        return (high_speed_baud_select ? 16 : 64) * (int'(dv) + 1);
    endfunction : bit_clocks

    // Bounded waits
    task automatic give_up;
        miscompares++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        end_sim();
    endtask : give_up
    task automatic wait_irq;
        int c;
        for (c = 0; c < 500 && irq !== 1'b1; c++) @(posedge clock);
        if (c == 500) give_up();
    endtask : wait_irq
    task automatic meas(output int p);
        logic prev;
        int n;
        p = -1;
        n = -1;
        prev = 1'b1;
        for (int c = 0; c < 400 && p < 0; c++) begin
            @(posedge clock);
            #1;
            if (tx_clock_pin_out === 1'b1 && prev === 1'b0) begin
                if (n >= 0) p = c - n;
                n = c;
            end
            prev = tx_clock_pin_out;
        end
        if (p < 0) give_up();
    endtask : meas

    // One asynchronous character, then data, flags and status
    task automatic rx_case(input int k);
        logic [8:0] d;
        logic [7:0] dv, c, m, v;
        d = 9'($random(seed));
        dv = 8'(($random(seed) & 1) + 1);
        c = {1'b1, k[1], 6'h10};
        m = k[1] ? 8'hff : 8'hfe;
        wr(ADDR_TX_CTRL, {5'h00, k[0], 2'h0});
        wr(ADDR_RX_CTRL, c);
        wr(ADDR_BAUD_DIV, dv);
        i_peer.send(d, k[1], k != 3, bit_clocks(1'b0, k[0], dv), k == 4);
        wait_irq();
        rd(ADDR_RX_CTRL, v);
        chk(v & m, {c[7:4], 1'b0, k == 3, 1'b0, d[8]} & m);
        rdc(ADDR_IRQ_STAT, {6'h0, k == 3, 1'b1});
        wr(ADDR_IRQ_STAT, 8'h07);
        chk_irq(1'b0);
        rdc(ADDR_RX_DATA, d[7:0]);
    endtask : rx_case

    // Main sequence
    initial begin
        logic [7:0] v, w;
        int p;
        seed = 78;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        // Reset values, fixed bits and unmapped place
        rdc(ADDR_RX_CTRL, RX_CTRL_RST);
        rdc(ADDR_TX_CTRL, TX_CTRL_RST);
        rdc(ADDR_BAUD_DIV, BAUD_DIV_RST);
        rdc(8'h55, 8'h00);
        wr(ADDR_RX_CTRL, 8'hff);
        rdc(ADDR_RX_CTRL, 8'hf0);
        wr(ADDR_RX_CTRL, 8'h00);
        wr(ADDR_TX_CTRL, 8'hff);
        rdc(ADDR_TX_CTRL, 8'hf7);
        wr(ADDR_BAUD_DIV, 8'ha5);
        rdc(ADDR_BAUD_DIV, 8'ha5);
        // Pin hand-over for every enable and direction pair
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_RX_CTRL, {i[2], 7'h00});
            pin_dir_in <= i[1:0];
            chk_irq(1'b0);
            chk({7'h0, pins_serial}, {7'h0, i[2] & i[1] & i[0]});
        end
        // Asynchronous characters in every width and speed
        wr(ADDR_IRQ_MASK, 8'h07);
        rdc(ADDR_IRQ_MASK, 8'h07);
        for (int k = 0; k < 6; k++) rx_case(k);
        // No reception without continuous receive
        wr(ADDR_BAUD_DIV, 8'h01);
        wr(ADDR_RX_CTRL, 8'h80);
        i_peer.send(9'h055, 1'b0, 1'b1, bit_clocks(1'b0, 1'b1, 8'h01), 1'b0);
        repeat (20) @(posedge clock);
        rdc(ADDR_IRQ_STAT, 8'h00);
        // Overrun, masking and clearing
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_RX_CTRL, 8'h90);
        repeat (3) i_peer.send(9'($random(seed)), 1'b0, 1'b1, bit_clocks(1'b0, 1'b1, 8'h01), 1'b0);
        repeat (20) @(posedge clock);
        rdc(ADDR_IRQ_STAT, 8'h05);
        chk_irq(1'b0);
        wr(ADDR_IRQ_MASK, 8'h04);
        chk_irq(1'b1);
        wr(ADDR_IRQ_STAT, 8'h04);
        chk_irq(1'b0);
        wr(ADDR_RX_CTRL, 8'h9e);
        rd(ADDR_RX_CTRL, v);
        chk(v & 8'hfe, 8'h92);
        wr(ADDR_RX_CTRL, 8'h80);
        rd(ADDR_RX_CTRL, v);
        chk(v & 8'hfe, 8'h80);
        rd(ADDR_RX_DATA, v);
        wr(ADDR_IRQ_STAT, 8'h07);
        // Synchronous master at both speed settings
        for (int b = 0; b < 2; b++) begin
            w = 8'($random(seed) & 3);
            wr(ADDR_BAUD_DIV, w);
            wr(ADDR_TX_CTRL, {5'h12, b[0], 2'h0});
            wr(ADDR_RX_CTRL, 8'ha0);
            meas(p);
            chk(8'(p), 8'(bit_clocks(1'b1, b[0], w)));
            chk({7'h0, tx_clock_pin_oe}, 8'h01);
            for (p = 0; p < 200; p++) begin
                rd(ADDR_RX_CTRL, v);
                if (v[5] === 1'b0) break;
            end
            chk(v & 8'h20, 8'h00);
            rd(ADDR_RX_DATA, v);
        end
        // Continuous receive keeps the clock going past one character
        wr(ADDR_RX_CTRL, 8'hb0);
        repeat (12 * bit_clocks(1'b1, 1'b1, w)) @(posedge clock);
        meas(p);
        chk(8'(p), 8'(bit_clocks(1'b1, 1'b0, w)));
        // Slave takes its clock from the peer; the idle line shifts in ones
        wr(ADDR_RX_CTRL, 8'h80);
        wr(ADDR_TX_CTRL, 8'h10);
        rd(ADDR_RX_DATA, v);
        wr(ADDR_IRQ_STAT, 8'h07);
        chk_irq(1'b0);
        wr(ADDR_RX_CTRL, 8'h90);
        chk_irq(1'b0);
        chk({7'h0, tx_clock_pin_oe}, 8'h00);
        repeat (8) begin
            @(posedge clock);
            tx_clock_pin_in <= 1'b1;
            repeat (4) @(posedge clock);
            tx_clock_pin_in <= 1'b0;
            repeat (3) @(posedge clock);
        end
        rdc(ADDR_RX_DATA, 8'hff);
        rdc(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_RX_CTRL, 8'h00);
        end_sim();
    end
endmodule : test_usart_rx_control_baud_gen
